// >>> hdl/codec_config_coef_backup.sv
`timescale 1ns/1ps
`include "codec_cfg_params.svh"
module codec_config_coef_backup (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Direct access port
  input wire logic dir_wr,
  input wire logic dir_rd,
  input wire logic [7:0] dir_addr,
  input wire logic [7:0] dir_wdata,
  output logic [7:0] dir_rdata,
  // Command stream: a strobe per byte, first byte is the command word
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_end,
  output logic cmd_ready,
  output logic resp_valid,
  output logic [7:0] resp_byte,
  // DSP coefficient port
  input wire logic [6:0] dsp_addr,
  output logic [7:0] dsp_data,
  // Decoded control outputs
  output logic speakerphone_on,
  output logic tx_agc_en,
  output logic rx_agc_en,
  output logic rx_modified_gain,
  output logic controlled_monitor_en,
  output logic power_up,
  output logic rx_atten_ch2,
  output logic rx_atten_ch1,
  output logic [7:0] filter_enables,
  output logic ring_via_speaker,
  output logic ring_receive_dir,
  output logic touch_tone_mode,
  output logic ring_transmit_dir,
  output logic speaker_single_ended,
  output logic handset_pos_hiz,
  output logic handset_neg_hiz,
  output logic speaker_pos_hiz,
  output logic speaker_neg_hiz,
  output logic [3:0] handset_amp_level,
  output logic [3:0] speaker_amp_level,
  output logic [1:0] fmt_ch2_rx,
  output logic [1:0] fmt_ch2_tx,
  output logic [1:0] fmt_ch1_rx,
  output logic [1:0] fmt_ch1_tx,
  output logic backup_busy
);
  // ==========================================================
  // Declarations
  logic [3:0] coef_block_select_q;
  logic dsp_temp_block_select_q;
  logic busy_q;
  logic [2:0] copy_idx_q;
  logic [3:0] copy_block_q;
  codec_cfg_pkg::cmd_state_t state_q;
  codec_cfg_pkg::cmd_target_t tgt_q;
  logic read_q;
  logic [3:0] left_q;
  logic [3:0] index_q;
  logic auto_backup_q;
  logic [3:0] auto_block_q;
  logic reg_wr;
  logic [2:0] reg_idx;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [63:0] reg_flat;
  logic cram_wr;
  logic [6:0] cram_addr;
  logic [7:0] cram_wdata;
  logic [7:0] cram_rdata;
  logic start_req;
  logic [3:0] start_block;
  logic dir_reg_hit;
  logic dir_cram_hit;
  logic [7:0] status_byte;
  logic [7:0] control_byte;

  // ==========================================================
  // Direct address decode
  assign dir_reg_hit = dir_addr[7:4] == `CFG_BASE_HI && dir_addr[3] == 1'b0;
  assign dir_cram_hit = dir_addr[`CRAM_BASE_BIT];
  assign control_byte = {1'b0, 2'h0, dsp_temp_block_select_q, coef_block_select_q};
  assign status_byte = {7'h00, busy_q};

  // ==========================================================
  // Register and RAM port steering; command stream has priority in its data phase
  always_comb begin
    reg_wr = 1'b0;
    reg_idx = dir_addr[2:0];
    reg_wdata = dir_wdata;
    cram_wr = 1'b0;
    cram_addr = dir_addr[6:0];
    cram_wdata = dir_wdata;
    if (state_q == codec_cfg_pkg::CMD_DATA && cmd_valid && !read_q) begin
      if (tgt_q == codec_cfg_pkg::TGT_REG) begin
        reg_wr = 1'b1;
        reg_idx = index_q[2:0];
        reg_wdata = cmd_byte;
      end else if (tgt_q == codec_cfg_pkg::TGT_VOL && index_q == 4'h0) begin
        reg_wr = 1'b1; // First volume byte is the receive amplifier register
        reg_idx = 3'h6;
        reg_wdata = cmd_byte;
      end else if (tgt_q != codec_cfg_pkg::TGT_NONE) begin
        cram_wr = 1'b1;
        cram_addr = (tgt_q == codec_cfg_pkg::TGT_VOL) ? `VOL_COEF_BASE + 7'(index_q - 4'h1)
                                                      : {auto_block_q, index_q[2:0]};
        cram_wdata = cmd_byte;
      end
    end else if (state_q == codec_cfg_pkg::CMD_DATA && read_q) begin
      reg_idx = (tgt_q == codec_cfg_pkg::TGT_VOL) ? 3'h6 : index_q[2:0];
      cram_addr = (tgt_q == codec_cfg_pkg::TGT_VOL) ? `VOL_COEF_BASE + 7'(index_q - 4'h1)
                                                    : {auto_block_q, index_q[2:0]};
    end else begin
      // is the host's duty; writes during a copy are still honoured
      reg_wr = dir_wr && dir_reg_hit;
      cram_wr = dir_wr && dir_cram_hit;
    end
  end

  // ==========================================================
  // Direct read data
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dir_rdata <= 8'h00;
    end else if (dir_rd) begin
      if (dir_cram_hit) dir_rdata <= cram_rdata;
      else if (dir_reg_hit) dir_rdata <= reg_rdata;
      else if (dir_addr == `ADDR_BACKUP_CONTROL) dir_rdata <= control_byte;
      else if (dir_addr == `ADDR_BACKUP_STATUS) dir_rdata <= status_byte;
      else dir_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // Backup control register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      coef_block_select_q <= 4'h0;
      dsp_temp_block_select_q <= 1'b0;
    end else if (dir_wr && dir_addr == `ADDR_BACKUP_CONTROL) begin
      coef_block_select_q <= dir_wdata[`BK_BLOCK_LSB +: 4];
      dsp_temp_block_select_q <= dir_wdata[`BK_DSP_SEL_BIT];
    end
  end

  assign start_req = (dir_wr && dir_addr == `ADDR_BACKUP_CONTROL && dir_wdata[`BK_START_BIT])
                     || (state_q == codec_cfg_pkg::CMD_BACKUP);
  assign start_block = (state_q == codec_cfg_pkg::CMD_BACKUP) ? auto_block_q
                                                              : dir_wdata[`BK_BLOCK_LSB +: 4];

  // ==========================================================
  // Block copy engine, one byte per clock
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      copy_idx_q <= 3'h0;
      copy_block_q <= 4'h0;
    end else if (!busy_q && start_req) begin
      busy_q <= 1'b1;
      copy_idx_q <= 3'h0;
      copy_block_q <= start_block;
    end else if (busy_q) begin
      copy_idx_q <= copy_idx_q + 3'h1;
      if (copy_idx_q == 3'(`BLOCK_BYTES - 1)) busy_q <= 1'b0;
    end
  end
  assign backup_busy = busy_q;

  // ==========================================================
  // Command sequence decoder
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= codec_cfg_pkg::CMD_IDLE;
      tgt_q <= codec_cfg_pkg::TGT_NONE;
      read_q <= 1'b0;
      left_q <= 4'h0;
      index_q <= 4'h0;
      auto_backup_q <= 1'b0;
      auto_block_q <= 4'h0;
    end else begin
      case (state_q)
        codec_cfg_pkg::CMD_IDLE: begin
          if (cmd_valid) begin
            read_q <= cmd_byte[`CMD_DIR_BIT];
            index_q <= 4'h0;
            auto_block_q <= cmd_byte[3:0];
            auto_backup_q <= 1'b0;
            state_q <= codec_cfg_pkg::CMD_DATA;
            case (cmd_byte[5:4])
              `CMD_CLASS_SOP: begin
                tgt_q <= codec_cfg_pkg::TGT_REG;
                left_q <= (cmd_byte[3:0] == 4'hF) ? 4'h8 : 4'(`SOP_SEQ_LEN - 1);
                index_q <= (cmd_byte[3:0] == 4'hF) ? 4'h7 : {1'b0, cmd_byte[2:0]};
                if (cmd_byte[3]) tgt_q <= codec_cfg_pkg::TGT_NONE;
                if (cmd_byte[3:0] == 4'hF) tgt_q <= codec_cfg_pkg::TGT_REG;
              end
              `CMD_CLASS_COP: begin
                tgt_q <= codec_cfg_pkg::TGT_CRAM;
                left_q <= 4'(`COP_SEQ_LEN - 1);
                auto_backup_q <= !cmd_byte[`CMD_DIR_BIT];
                // Save the old block first so the DSP has a whole set while bytes are rewritten
                if (!cmd_byte[`CMD_DIR_BIT]) state_q <= codec_cfg_pkg::CMD_BACKUP;
              end
              `CMD_CLASS_XOP: begin
                if (cmd_byte[3:0] == `XOP_VOLUME) begin
                  tgt_q <= codec_cfg_pkg::TGT_VOL;
                  left_q <= 4'(`VOLUME_SEQ_LEN - 1);
                end else begin
                  state_q <= codec_cfg_pkg::CMD_IDLE; // No-op and unknown codes are one byte
                end
              end
              default: state_q <= codec_cfg_pkg::CMD_SKIP;
            endcase
          end
        end
        codec_cfg_pkg::CMD_DATA: begin
          if (cmd_valid || read_q) begin
            left_q <= left_q - 4'h1;
            // The combined register sequence walks downward from the last register
            index_q <= (tgt_q == codec_cfg_pkg::TGT_REG && left_q > 4'h1) ? index_q - 4'h1 : index_q + 4'h1;
            if (left_q == 4'h1 || cmd_end) begin
              state_q <= codec_cfg_pkg::CMD_IDLE;
              auto_backup_q <= 1'b0;
            end
          end
        end
        codec_cfg_pkg::CMD_BACKUP: begin
          if (busy_q && copy_idx_q == 3'(`BLOCK_BYTES - 1)) state_q <= codec_cfg_pkg::CMD_DATA;
        end
        codec_cfg_pkg::CMD_SKIP: begin
          if (cmd_end) state_q <= codec_cfg_pkg::CMD_IDLE;
        end
        default: state_q <= codec_cfg_pkg::CMD_IDLE;
      endcase
    end
  end

  assign cmd_ready = state_q != codec_cfg_pkg::CMD_BACKUP;

  // ==========================================================
  // Read answers on the command stream
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      resp_valid <= 1'b0;
      resp_byte <= 8'h00;
    end else begin
      resp_valid <= state_q == codec_cfg_pkg::CMD_DATA && read_q;
      resp_byte <= (tgt_q == codec_cfg_pkg::TGT_CRAM || (tgt_q == codec_cfg_pkg::TGT_VOL && index_q != 4'h0))
                   ? cram_rdata : reg_rdata;
    end
  end

  // ==========================================================
  // Storage
  cfg_regs u_regs (
    .clock(clock),
    .arst_n(arst_n),
    .wr_en(reg_wr),
    .idx(reg_idx),
    .wr_data(reg_wdata),
    .rd_data(reg_rdata),
    .flat(reg_flat)
  );

  coef_ram #(.BLOCKS(16), .BLOCK_BYTES(`BLOCK_BYTES)) u_cram (
    .clock(clock),
    .arst_n(arst_n),
    .wr_en(cram_wr),
    .wr_addr(cram_addr),
    .wr_data(cram_wdata),
    .rd_addr(cram_addr),
    .rd_data(cram_rdata),
    .copy_en(busy_q),
    .copy_idx(copy_idx_q),
    .copy_block(copy_block_q),
    .dsp_temp_sel(dsp_temp_block_select_q || (auto_backup_q && state_q == codec_cfg_pkg::CMD_DATA)),
    .dsp_addr(dsp_addr),
    .dsp_data(dsp_data)
  );

  // ==========================================================
  // Field decode; the two AGC enables act only with speakerphone on
  assign speakerphone_on = reg_flat[7];
  assign tx_agc_en = reg_flat[6] && reg_flat[7];
  assign rx_agc_en = reg_flat[5] && reg_flat[7];
  assign rx_modified_gain = reg_flat[4];
  assign controlled_monitor_en = reg_flat[3];
  assign power_up = reg_flat[2];
  assign rx_atten_ch2 = reg_flat[1];
  assign rx_atten_ch1 = reg_flat[0];
  assign filter_enables = reg_flat[15:8];
  assign ring_via_speaker = reg_flat[30];
  assign ring_receive_dir = reg_flat[28];
  assign touch_tone_mode = reg_flat[27];
  assign ring_transmit_dir = reg_flat[26];
  assign speaker_single_ended = reg_flat[36];
  assign handset_pos_hiz = reg_flat[35];
  assign handset_neg_hiz = reg_flat[34];
  assign speaker_pos_hiz = reg_flat[33];
  assign speaker_neg_hiz = reg_flat[32];
  assign handset_amp_level = reg_flat[55:52];
  assign speaker_amp_level = reg_flat[51:48];
  assign fmt_ch2_rx = reg_flat[63:62];
  assign fmt_ch2_tx = reg_flat[61:60];
  assign fmt_ch1_rx = reg_flat[59:58];
  assign fmt_ch1_tx = reg_flat[57:56];
endmodule // codec_config_coef_backup

// >>> common/codec_cfg_params.svh
`ifndef CODEC_CFG_PARAMS_SVH
`define CODEC_CFG_PARAMS_SVH
// Direct register addresses
`define ADDR_GENERAL_CONTROL 8'h60
`define ADDR_FILTER_GAIN 8'h61
`define ADDR_TONE_GEN 8'h62
`define ADDR_TONE_ROUTING 8'h63
`define ADDR_ANALOG_OUTPUT 8'h64
`define ADDR_ANALOG_TX 8'h65
`define ADDR_ANALOG_RX 8'h66
`define ADDR_DATA_FORMAT 8'h67
`define ADDR_BACKUP_CONTROL 8'h70
`define ADDR_BACKUP_STATUS 8'h71
`define CFG_BASE_HI 4'h6
`define CRAM_BASE_BIT 7
// Command word fields
`define CMD_DIR_BIT 7
`define CMD_CLASS_SOP 2'h1
`define CMD_CLASS_COP 2'h2
`define CMD_CLASS_XOP 2'h3
`define XOP_VOLUME 4'h6
`define XOP_NOP 4'hF
`define VOLUME_SEQ_LEN 3'h6
`define COP_SEQ_LEN 4'h9
`define SOP_SEQ_LEN 4'h2
// Volume sequence coefficient locations in the coefficient RAM
`define VOL_COEF_BASE 7'h68
// Backup control fields
`define BK_BLOCK_LSB 0
`define BK_DSP_SEL_BIT 4
`define BK_START_BIT 7
`define BK_BUSY_BIT 0
`define BLOCK_BYTES 8
// Reset values
`define REG_RESET 8'h00
`endif

// >>> common/codec_cfg_pkg.sv
package codec_cfg_pkg;
  typedef enum logic [3:0] {
    CMD_IDLE = 4'b0001,
    CMD_DATA = 4'b0010,
    CMD_BACKUP = 4'b0100,
    CMD_SKIP = 4'b1000
  } cmd_state_t;
  typedef enum logic [1:0] {
    TGT_REG = 2'h0,
    TGT_CRAM = 2'h1,
    TGT_VOL = 2'h2,
    TGT_NONE = 2'h3
  } cmd_target_t;
endpackage

// >>> hdl/coef_ram.sv
`timescale 1ns/1ps
// Coefficient storage with a temporary block for the DSP side
module coef_ram #(
  parameter int BLOCKS = 16,
  parameter int BLOCK_BYTES = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data,
  // Temporary block copy
  input wire logic copy_en,
  input wire logic [2:0] copy_idx,
  input wire logic [3:0] copy_block,
  // DSP port
  input wire logic dsp_temp_sel,
  input wire logic [6:0] dsp_addr,
  output logic [7:0] dsp_data
);
  initial begin
    if (BLOCKS * BLOCK_BYTES != 128) $error("coef_ram: size must be 128 bytes");
  end
  logic [7:0] mem_q [BLOCKS*BLOCK_BYTES];
  logic [7:0] temp_q [BLOCK_BYTES];

  genvar i;
  generate
    for (i = 0; i < BLOCKS * BLOCK_BYTES; i++) begin : g_mem
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          mem_q[i] <= 8'h00;
        end else if (wr_en && wr_addr == 7'(i)) begin
          mem_q[i] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int k = 0; k < BLOCK_BYTES; k++) temp_q[k] <= 8'h00;
    end else if (copy_en) begin
      temp_q[copy_idx] <= mem_q[{copy_block, copy_idx}];
    end
  end

  assign rd_data = mem_q[rd_addr];
  // DSP reads the temporary block when selected, index by low address bits
  assign dsp_data = dsp_temp_sel ? temp_q[dsp_addr[2:0]] : mem_q[dsp_addr];
endmodule // coef_ram

// >>> hdl/cfg_regs.sv
`timescale 1ns/1ps
`include "codec_cfg_params.svh"
// Eight codec configuration registers, indexed by low address bits
module cfg_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Access
  input wire logic wr_en,
  input wire logic [2:0] idx,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  // Contents
  output logic [63:0] flat
);
  logic [7:0] reg_q [8];
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_reg
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          reg_q[i] <= `REG_RESET;
        end else if (wr_en && idx == 3'(i)) begin
          reg_q[i] <= wr_data;
        end
      end
      assign flat[i*8 +: 8] = reg_q[i];
    end
  endgenerate
  assign rd_data = reg_q[idx];
endmodule // cfg_regs

// >>> testbench/codec_cfg_chk_sva.sv
`timescale 1ns/1ps
// ==========================
// Port checker: back-up timing, read path, decoded fields
module codec_cfg_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Direct access
  input wire logic dir_wr,
  input wire logic dir_rd,
  input wire logic [7:0] dir_addr,
  input wire logic [7:0] dir_wdata,
  input wire logic [7:0] dir_rdata,
  // Decoded fields and status
  input wire logic [7:0] filter_enables,
  input wire logic [3:0] handset_amp_level,
  input wire logic [3:0] speaker_amp_level,
  input wire logic ring_via_speaker,
  input wire logic ring_receive_dir,
  input wire logic touch_tone_mode,
  input wire logic ring_transmit_dir,
  input wire logic backup_busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence start_req;
    dir_wr && dir_addr == 8'h70 && dir_wdata[7] && !backup_busy;
  endsequence
  sequence copy_run;
    backup_busy [*8] ##1 !backup_busy;
  endsequence
  busy_start_a: assert property (start_req |=> copy_run)
    else $error("copy did not start and run eight cycles");
  busy_len_a: assert property ($rose(backup_busy) |-> copy_run)
    else $error("busy length is not eight cycles");
  busy_read_a: assert property (dir_rd && dir_addr == 8'h71 |=> dir_rdata == {7'h00, $past(backup_busy)})
    else $error("status read does not show busy");
  unmapped_read_a: assert property (dir_rd && dir_addr < 8'h60 |=> dir_rdata == 8'h00)
    else $error("unmapped read not zero");
  filter_read_a: assert property (dir_rd && dir_addr == 8'h61 |=> dir_rdata == $past(filter_enables))
    else $error("filter read differs from decoded byte");
  filter_map_a: assert property (dir_wr && dir_addr == 8'h61 |=> filter_enables == $past(dir_wdata))
    else $error("filter enables not updated");
  amp_map_a: assert property (dir_wr && dir_addr == 8'h66 |=>
    {handset_amp_level, speaker_amp_level} == $past(dir_wdata)) else $error("amp levels wrong");
  tone_map_a: assert property (dir_wr && dir_addr == 8'h63 |=>
    {ring_via_speaker, ring_receive_dir, touch_tone_mode, ring_transmit_dir} == {$past(dir_wdata[6]),
    $past(dir_wdata[4]), $past(dir_wdata[3]), $past(dir_wdata[2])}) else $error("tone routing bits wrong");
endmodule // codec_cfg_chk

bind codec_config_coef_backup codec_cfg_chk CHK (.clock, .arst_n, .dir_wr, .dir_rd, .dir_addr, .dir_wdata,
  .dir_rdata, .filter_enables, .handset_amp_level, .speaker_amp_level, .ring_via_speaker, .ring_receive_dir,
  .touch_tone_mode, .ring_transmit_dir, .backup_busy);

// >>> testbench/host_model.sv
`timescale 1ns/1ps
// ==========================
// Microcontroller: direct accesses and command bytes, driven on falling edges
module host_model (
  // Clock
  input wire logic clock,
  // Direct access
  output logic dir_wr,
  output logic dir_rd,
  output logic [7:0] dir_addr,
  output logic [7:0] dir_wdata,
  input wire logic [7:0] dir_rdata,
  input wire logic backup_busy,
  // Command stream
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic cmd_end,
  input wire logic cmd_ready
);
  initial begin
    {dir_wr, dir_rd, cmd_valid, cmd_end} = 4'h0;
    {dir_addr, dir_wdata, cmd_byte} = 24'h000000;
  end
  // Bounded so a stuck flag cannot hang the run
  task automatic idle_wait();
    for (int n = 0; n < 50 && backup_busy !== 1'b0; n++) @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    // One idle edge between transfers keeps every strobe a clean pulse
    @(negedge clock);
    idle_wait();
    dir_wr = 1'b1;
    dir_addr = a;
    dir_wdata = d;
    @(negedge clock);
    dir_wr = 1'b0;
    // Released lines show the inverse so stale values cannot pass
    dir_addr = ~a;
    dir_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    idle_wait();
    dir_rd = 1'b1;
    dir_addr = a;
    @(negedge clock);
    dir_rd = 1'b0;
    dir_addr = ~a;
    d = dir_rdata;
  endtask
  task automatic cmd(input logic [7:0] b, input logic last);
    @(negedge clock);
    idle_wait();
    for (int n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(negedge clock);
    cmd_valid = 1'b1;
    cmd_byte = b;
    cmd_end = last;
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_end = 1'b0;
    cmd_byte = ~b;
  endtask
endmodule // host_model

// >>> testbench/codec_config_coef_backup_tb_top.sv
`timescale 1ns/1ps
// ==========================
// Bench top: host model, design and reference arrays
module codec_config_coef_backup_tb_top;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [6:0] dsp_addr = 7'h00;
  logic dir_wr, dir_rd, cmd_valid, cmd_end, cmd_ready, resp_valid, backup_busy;
  logic [7:0] dir_addr, dir_wdata, dir_rdata, cmd_byte, resp_byte, dsp_data, filter_enables, v;
  logic speakerphone_on, tx_agc_en, rx_agc_en, rx_modified_gain, controlled_monitor_en, power_up;
  logic rx_atten_ch2, rx_atten_ch1, ring_via_speaker, ring_receive_dir, touch_tone_mode, ring_transmit_dir;
  logic speaker_single_ended, handset_pos_hiz, handset_neg_hiz, speaker_pos_hiz, speaker_neg_hiz;
  logic [3:0] handset_amp_level, speaker_amp_level;
  logic [1:0] fmt_ch2_rx, fmt_ch2_tx, fmt_ch1_rx, fmt_ch1_tx;
  logic [7:0] regs_m [8];
  logic [7:0] ram_m [128];
  logic [63:0] tmp;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int blk;

  always #25 clock = ~clock;

  host_model HOST (.clock, .dir_wr, .dir_rd, .dir_addr, .dir_wdata, .dir_rdata, .backup_busy,
    .cmd_valid, .cmd_byte, .cmd_end, .cmd_ready);
  codec_config_coef_backup DUT (.clock, .arst_n, .dir_wr, .dir_rd, .dir_addr, .dir_wdata, .dir_rdata,
    .cmd_valid, .cmd_byte, .cmd_end, .cmd_ready, .resp_valid, .resp_byte, .dsp_addr, .dsp_data,
    .speakerphone_on, .tx_agc_en, .rx_agc_en, .rx_modified_gain, .controlled_monitor_en, .power_up,
    .rx_atten_ch2, .rx_atten_ch1, .filter_enables, .ring_via_speaker, .ring_receive_dir, .touch_tone_mode,
    .ring_transmit_dir, .speaker_single_ended, .handset_pos_hiz, .handset_neg_hiz, .speaker_pos_hiz,
    .speaker_neg_hiz, .handset_amp_level, .speaker_amp_level, .fmt_ch2_rx, .fmt_ch2_tx, .fmt_ch1_rx,
    .fmt_ch1_tx, .backup_busy);

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    HOST.rd(a, d);
    chk("dir_rdata", e, d);
  endtask
  task automatic dsp_chk(input int b, input logic [63:0] e);
    for (int i = 0; i < 8; i++) begin
      dsp_addr = 7'(b * 8 + i);
      @(negedge clock);
      chk("dsp_data", e[i*8 +: 8], dsp_data);
    end
  endtask
  function automatic logic [63:0] blk_m(input int b);
    for (int i = 0; i < 8; i++) blk_m[i*8 +: 8] = ram_m[b * 8 + i];
  endfunction
  task give_verdict();
    if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(32'hCB2704F2));
    repeat (16) @(negedge clock);
    arst_n = 1'b1;
    @(negedge clock);
    for (int i = 0; i < 8; i++) rd_chk(8'(8'h60 + i), 8'h00);
    rd_chk(8'h71, 8'h00);
    // ==========================
    // Direct register writes and decoded fields
    for (int i = 0; i < 8; i++) begin
      regs_m[i] = 8'($urandom);
      HOST.wr(8'(8'h60 + i), regs_m[i]);
    end
    chk("general_control", regs_m[0] & (regs_m[0][7] ? 8'hFF : 8'h9F), {speakerphone_on, tx_agc_en,
      rx_agc_en, rx_modified_gain,
      controlled_monitor_en, power_up, rx_atten_ch2, rx_atten_ch1});
    chk("filter", regs_m[1], filter_enables);
    chk("tone", regs_m[3] & 8'h5C, {1'b0, ring_via_speaker, 1'b0, ring_receive_dir, touch_tone_mode,
      ring_transmit_dir, 2'h0});
    chk("analog", regs_m[4] & 8'h1F, {3'h0, speaker_single_ended, handset_pos_hiz, handset_neg_hiz,
      speaker_pos_hiz, speaker_neg_hiz});
    chk("amp", regs_m[6], {handset_amp_level, speaker_amp_level});
    chk("format", regs_m[7], {fmt_ch2_rx, fmt_ch2_tx, fmt_ch1_rx, fmt_ch1_tx});
    HOST.wr(8'h50, 8'hA5);
    rd_chk(8'h50, 8'h00);
    // ==========================
    // Manual back-up, then rewrite while the DSP reads the saved copy
    for (int i = 0; i < 128; i++) begin
      ram_m[i] = 8'($urandom);
      HOST.wr(8'(8'h80 + i), ram_m[i]);
    end
    blk = $urandom_range(15, 0);
    tmp = blk_m(blk);
    HOST.wr(8'h70, 8'(8'h80 + blk));
    for (v = 8'h00; v < 8'h14 && backup_busy === 1'b1; v++) @(negedge clock);
    chk("busy_cycles", 8'h08, v);
    HOST.wr(8'h70, 8'(8'h10 + blk));
    rd_chk(8'h70, 8'(8'h10 + blk));
    for (int i = 0; i < 8; i++) begin
      ram_m[blk * 8 + i] = 8'($urandom);
      HOST.wr(8'(8'h80 + blk * 8 + i), ram_m[blk * 8 + i]);
    end
    dsp_chk(blk, tmp);
    HOST.wr(8'h70, 8'h00);
    dsp_chk(blk, blk_m(blk));
    // ==========================
    // Command sequences: one register, eight registers, a block, volume, no-op
    regs_m[5] = 8'($urandom);
    HOST.cmd(8'h15, 1'b0);
    HOST.cmd(regs_m[5], 1'b1);
    HOST.cmd(8'h1F, 1'b0);
    for (int i = 0; i < 8; i++) begin
      regs_m[7 - i] = 8'($urandom);
      HOST.cmd(regs_m[7 - i], i == 7);
    end
    blk = $urandom_range(12, 0);
    tmp = blk_m(blk);
    HOST.cmd(8'(8'h20 + blk), 1'b0);
    chk("cmd_ready", 8'h00, {7'h00, cmd_ready});
    dsp_addr = 7'(blk * 8);
    for (int i = 0; i < 8; i++) begin
      ram_m[blk * 8 + i] = 8'($urandom);
      HOST.cmd(ram_m[blk * 8 + i], i == 7);
      if (i == 4) chk("dsp_data", tmp[7:0], dsp_data);
    end
    regs_m[6] = 8'($urandom);
    HOST.cmd(8'h36, 1'b0);
    HOST.cmd(regs_m[6], 1'b0);
    for (int i = 0; i < 4; i++) begin
      ram_m[8'h68 + i] = 8'($urandom);
      HOST.cmd(ram_m[8'h68 + i], i == 3);
    end
    HOST.cmd(8'hFF, 1'b1);
    // Reserved class swallows bytes up to the end mark
    HOST.cmd(8'h05, 1'b0);
    HOST.cmd(8'hA5, 1'b1);
    HOST.cmd(8'h95, 1'b1);
    @(negedge clock);
    chk("resp_valid", 8'h01, {7'h00, resp_valid});
    chk("resp_byte", regs_m[5], resp_byte);
    for (int i = 0; i < 8; i++) rd_chk(8'(8'h60 + i), regs_m[i]);
    for (int i = 0; i < 128; i++) rd_chk(8'(8'h80 + i), ram_m[i]);
    HOST.wr(8'h70, 8'(8'h10 + blk));
    dsp_chk(blk, tmp);
    give_verdict();
  end
endmodule // codec_config_coef_backup_tb_top
